// ===== verilog/vicr_pkg.sv
// package for the legacy display init configuration register bank
package vicr_pkg;
	localparam logic [7:0] VICR_OFF_CTRL = 8'h28;
	localparam logic [7:0] VICR_OFF_APER = 8'h2C;
	localparam logic [31:0] VICR_CTRL_RST = 32'h00000038;
	localparam logic [31:0] VICR_CTRL_WMASK = 32'h007FFFC7;
	localparam logic [31:0] VICR_APER_RST = 32'h00000000;
	localparam logic [31:0] VICR_APER_WMASK = 32'h1FFFFFFF;
	localparam int VICR_B_DIS = 0;
	localparam int VICR_B_EXTT = 1;
	localparam int VICR_B_CLUT8 = 2;
	localparam int VICR_B_EXTEN = 6;
	localparam int VICR_B_WAKE = 8;
	localparam int VICR_B_NODEC = 9;
	localparam int VICR_B_ALTRB = 10;
	localparam int VICR_B_FBLINK = 11;
	localparam int VICR_B_XSHIFT = 12;
	localparam int VICR_B_DAC = 13;
	localparam int VICR_B_BASE_LO = 14;
	localparam int VICR_B_NOREF = 22;
	localparam int VICR_B_WAP_LO = 0;
	localparam int VICR_B_RAP_LO = 10;
	localparam int VICR_B_CHAIN4 = 20;
	localparam int VICR_B_LOCK_LO = 21;
	localparam int VICR_REFRESH_BURST = 3;
	localparam logic [1:0] VICR_RESP_OKAY = 2'b00;
	localparam logic [1:0] VICR_RESP_SLVERR = 2'b10;
	typedef struct packed {
		logic core_disable;
		logic ext_timing;
		logic clut_8bit;
		logic ext_enable;
		logic wake_alt_port;
		logic legacy_decode_off;
		logic cfg_readback_on;
		logic fast_blink;
		logic no_scan_fetch;
		logic [7:0] base_page;
		logic chain4;
		logic [9:0] write_aper;
		logic [9:0] read_aper;
		logic [7:0] locks;
	} vicr_cfg_t;
endpackage : vicr_pkg

// ===== verilog/vicr_regs.sv
// axi4-lite register bank with core gating, aperture mapping and refresh scheduling
//
// Functional notes
// - extended shift-out bit set stops frame fetches during scan-out.
// - eight-bit base field places core region in 64 KB pages, reset zero.
// - refresh-on-blank enabled gives three refreshes after hblank, defers timeout.
// - refresh-on-blank disabled leaves timeout counter as sole refresh source.
// - core disable bit blocks all core access; reset enabled.
// - external timing bit takes sync from outside, not internal timing.
// - palette width bit picks 6-bit or 8-bit lookup entries.
// - wake-up select picks port 46e8 or 3C3 / base plus C3.
// - legacy decode disable stops legacy memory and io decodes.
// - alternate readback bit zero allows config readback through index 1c.
// - test bit selects fast blink when one.
// - aperture register holds 10-bit write and read apertures, 32 KB steps.
// - legacy window accesses map to board memory through the apertures.
// - control bit enables chain-4 sequential addressing for legacy window.
// - each set lock bit blocks writes to its register group.
// - horizontal lock guards timing indices 0 to 5 and 1a.
// - vertical lock guards index 6,7 bits,9,10,11 low,15,16,1b.
// - bits 23..25 lock index 17 bit 2, vsync and hsync polarity.
// - bits 26..28 lock clock select, ram enable, character clock.
// - extension enable; with it clear the alternate readback control applies.
// - legacy decode disable also blocks writes to ports 46e8 and 102.
`timescale 1ns/1ps
module vicr_regs #(
	parameter int TIMEOUT_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output vicr_pkg::vicr_cfg_t cfg,
	input wire logic core_req,
	output logic core_grant,
	input wire logic scan_out_active,
	input wire logic scan_fetch_req,
	output logic scan_fetch_grant,
	input wire logic legacy_mem_hit,
	input wire logic legacy_io_hit,
	output logic legacy_decode_ok,
	input wire logic [15:0] io_wr_port,
	input wire logic io_wr_req,
	output logic io_wr_ok,
	input wire logic [7:0] crtc_index,
	input wire logic crtc_wr,
	output logic [7:0] crtc_wr_mask,
	input wire logic misc_wr,
	output logic [7:0] misc_wr_mask,
	input wire logic seq_wr,
	input wire logic [7:0] seq_index,
	output logic [7:0] seq_wr_mask,
	output logic cfg_readback_en,
	output logic sync_from_external,
	output logic [15:0] wake_port,
	input wire logic [15:0] io_base,
	input wire logic [16:0] window_offset,
	input wire logic window_write,
	output logic [23:0] window_addr,
	output logic chain4_en,
	output logic fast_blink,
	output logic clut_8bit,
	input wire logic hblank_start,
	input wire logic [TIMEOUT_W-1:0] refresh_period,
	output logic refresh_req
);
	logic [31:0] ctrl_q;
	logic [31:0] aper_q;
	logic aw_held_q;
	logic w_held_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [1:0] burst_q;
	logic [TIMEOUT_W-1:0] tmo_q;
	logic refresh_q;

	// control word field map, low to high:
	//   bit 0      core disable, one blocks every core access
	//   bit 1      sync taken from outside instead of internal timing
	//   bit 2      palette width, zero six bits, one eight bits
	//   bits 5:3   reserved, read as ones, never written
	//   bit 6      extended timing registers enable
	//   bit 7      spare, writable and read back, stored only
	//   bit 8      wake-up port select
	//   bit 9      legacy memory and io decode off
	//   bit 10     alternate readback off when one
	//   bit 11     fast blink test bit
	//   bit 12     no frame fetch during scan-out
	//   bit 13     palette decode test bit, stored only
	//   bits 21:14 base page of the core region, 64 KB steps
	//   bit 22     refresh on blank off
	//   bits 31:23 reserved, read as zero
	//
	// aperture word field map, low to high:
	//   bits 9:0   write aperture, 32 KB steps
	//   bits 19:10 read aperture, 32 KB steps
	//   bit 20     chain-4 sequential addressing
	//   bit 21     horizontal timing lock
	//   bit 22     vertical timing lock
	//   bit 23     index 17 bit 2 lock
	//   bit 24     vsync polarity lock
	//   bit 25     hsync polarity lock
	//   bit 26     clock select lock
	//   bit 27     ram enable lock
	//   bit 28     character clock lock
	//   bits 31:29 reserved, read as zero
	//
	// bus timing:
	//   write address and data may arrive in either order
	//   a channel that arrives alone is held until its partner comes
	//   the response is raised one edge after both are present
	//   no new write is taken while a response is still pending
	//   a read answer comes one edge after the address is taken
	//   unmapped offsets answer with slave error and no side effect
	//
	// refresh timing:
	//   blank mode arms a three-cycle burst at hblank start
	//   the timeout counter is held at zero through the burst
	//   outside blank mode the counter alone paces refresh
	//   refresh period comes from a port so it can be tuned
	//
	// locks:
	//   locks shape write masks only; the held values stay readable
	//   the masks are zero whenever the matching write strobe is low
	//   a lock that does not cover the index leaves all bits writable
	//
	// hazards:
	//   decode outputs are combinational from stored state
	//   downstream logic must register them if it needs timing margin
	//   a disabled core also drops every grant and decode
	//   the window adder wraps silently inside 16 MB
	//   callers keep window offsets inside one 32 KB aperture
	//   only offset bits 14:0 reach the adder
	//   wstrb lanes left low keep their old byte
	//   reserved bits ignore writes regardless of strobes
	//
	// reset:
	//   synchronous, active low, on aclk
	//   all valids drop and both registers return to defaults
	//   the refresh burst and timeout counter return to zero
	//   write holding registers clear as well
	//
	// interfaces:
	//   the cfg bundle carries every decoded field except refresh on blank off as a level
	//   the window path selects write or read aperture per access
	//   wake port falls back to 3C3 when no io base is set
	//   io base plus C3 is used otherwise
	//   guarded io ports are refused while decode is off
	//   crtc, misc and sequencer masks are formed in parallel
	//   readback through index 1c needs extensions off too
	//   fast blink and palette width are plain level outputs
	//   chain-4 enable follows the aperture word directly
	//   bit 12 blocks scan fetches only while scan-out runs
	//   core requests see the disable bit with no delay
	//   legacy hits are merged before gating

	// write channel capture, either order
	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire = s_axi_wvalid && s_axi_wready;
	wire aw_have = aw_held_q || aw_fire;
	wire w_have = w_held_q || w_fire;
	wire do_write = aw_have && w_have && !bvalid_q;
	wire [7:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
	wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
	wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire wr_ctrl = do_write && (wr_addr[7:2] == vicr_pkg::VICR_OFF_CTRL[7:2]);
	wire wr_aper = do_write && (wr_addr[7:2] == vicr_pkg::VICR_OFF_APER[7:2]);
	wire wr_hit = wr_ctrl || wr_aper;
	wire [31:0] ctrl_wm = strb_mask & vicr_pkg::VICR_CTRL_WMASK;
	wire [31:0] aper_wm = strb_mask & vicr_pkg::VICR_APER_WMASK;
	wire [31:0] ctrl_d = (ctrl_q & ~ctrl_wm) | (wr_data & ctrl_wm);
	wire [31:0] aper_d = (aper_q & ~aper_wm) | (wr_data & aper_wm);

	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// read decode
	wire rd_ctrl = s_axi_araddr[7:2] == vicr_pkg::VICR_OFF_CTRL[7:2];
	wire rd_aper = s_axi_araddr[7:2] == vicr_pkg::VICR_OFF_APER[7:2];
	wire [31:0] rd_mux = rd_ctrl ? ctrl_q : (rd_aper ? aper_q : 32'h00000000);
	wire ar_fire = s_axi_arvalid && s_axi_arready;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// write address and data holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (aw_fire) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_fire) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			aw_held_q <= aw_have && !do_write;
			w_held_q <= w_have && !do_write;
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= vicr_pkg::VICR_RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? vicr_pkg::VICR_RESP_OKAY : vicr_pkg::VICR_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// register storage; reads always return held values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= vicr_pkg::VICR_CTRL_RST; // base page zero
			aper_q <= vicr_pkg::VICR_APER_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= ctrl_d;
			end
			if (wr_aper) begin
				aper_q <= aper_d;
			end
		end
	end

	// read response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= vicr_pkg::VICR_RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= (rd_ctrl || rd_aper) ? vicr_pkg::VICR_RESP_OKAY : vicr_pkg::VICR_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// configuration fields out
	assign cfg.core_disable = ctrl_q[vicr_pkg::VICR_B_DIS];
	assign cfg.ext_timing = ctrl_q[vicr_pkg::VICR_B_EXTT];
	assign cfg.clut_8bit = ctrl_q[vicr_pkg::VICR_B_CLUT8];
	assign cfg.ext_enable = ctrl_q[vicr_pkg::VICR_B_EXTEN];
	assign cfg.wake_alt_port = ctrl_q[vicr_pkg::VICR_B_WAKE];
	assign cfg.legacy_decode_off = ctrl_q[vicr_pkg::VICR_B_NODEC];
	assign cfg.cfg_readback_on = !ctrl_q[vicr_pkg::VICR_B_ALTRB];
	assign cfg.fast_blink = ctrl_q[vicr_pkg::VICR_B_FBLINK];
	assign cfg.no_scan_fetch = ctrl_q[vicr_pkg::VICR_B_XSHIFT];
	assign cfg.base_page = ctrl_q[vicr_pkg::VICR_B_BASE_LO +: 8];
	assign cfg.chain4 = aper_q[vicr_pkg::VICR_B_CHAIN4];
	assign cfg.write_aper = aper_q[vicr_pkg::VICR_B_WAP_LO +: 10];
	assign cfg.read_aper = aper_q[vicr_pkg::VICR_B_RAP_LO +: 10];
	assign cfg.locks = aper_q[vicr_pkg::VICR_B_LOCK_LO +: 8];

	// core access gating
	wire core_on = !cfg.core_disable;
	assign core_grant = core_req && core_on;
	assign scan_fetch_grant = scan_fetch_req && core_on
		&& !(cfg.no_scan_fetch && scan_out_active);
	assign legacy_decode_ok = (legacy_mem_hit || legacy_io_hit) && core_on
		&& !cfg.legacy_decode_off;
	wire guarded_port = (io_wr_port == 16'h46E8) || (io_wr_port == 16'h0102);
	assign io_wr_ok = io_wr_req && core_on
		&& !(cfg.legacy_decode_off && guarded_port);

	// decode test bit has no hardware effect; software keeps it zero
	// readback via index 1c only while extensions off and alt bit zero
	assign cfg_readback_en = cfg.cfg_readback_on && !cfg.ext_enable;
	assign sync_from_external = cfg.ext_timing;
	assign clut_8bit = cfg.clut_8bit;
	assign fast_blink = cfg.fast_blink;
	assign chain4_en = cfg.chain4;
	wire [15:0] alt_port = (io_base == 16'h0000) ? 16'h03C3 : io_base + 16'h00C3;
	assign wake_port = cfg.wake_alt_port ? alt_port : 16'h46E8;

	// legacy window into board memory, 32 KB aperture plus 64 KB base page
	wire [9:0] aper_sel = window_write ? cfg.write_aper : cfg.read_aper;
	wire [24:0] aper_addr = {aper_sel, 15'h0000} + {10'h000, window_offset[14:0]};
	wire [23:0] base_addr = {cfg.base_page, 16'h0000};
	wire [23:0] win_sum = base_addr + aper_addr[23:0];
	assign window_addr = win_sum;

	// register write locks per crtc index
	logic [7:0] crtc_m;
	always_comb begin
		crtc_m = 8'hFF;
		if (cfg.locks[0]) begin
			if (crtc_index <= 8'h05 || crtc_index == 8'h1A) crtc_m = 8'h00;
		end
		if (cfg.locks[1]) begin
			unique case (crtc_index)
				8'h06, 8'h09, 8'h10, 8'h15, 8'h16, 8'h1B: crtc_m = 8'h00;
				8'h07: crtc_m = crtc_m & 8'h52;
				8'h11: crtc_m = crtc_m & 8'hF0;
				default: crtc_m = crtc_m;
			endcase
		end
		if (cfg.locks[2] && crtc_index == 8'h17) crtc_m = crtc_m & 8'hFB;
	end
	assign crtc_wr_mask = crtc_wr ? crtc_m : 8'h00;
	// misc output port locks
	wire [7:0] misc_m = ~{cfg.locks[3], cfg.locks[4], 2'b00, cfg.locks[5], cfg.locks[5],
		cfg.locks[6], 1'b0};
	assign misc_wr_mask = misc_wr ? misc_m : 8'h00;
	wire [7:0] seq_m = (cfg.locks[7] && seq_index == 8'h01) ? 8'hFE : 8'hFF;
	assign seq_wr_mask = seq_wr ? seq_m : 8'h00;

	// refresh scheduling: burst after hblank, else timeout
	wire tmo_hit = (tmo_q >= refresh_period);
	wire blank_mode = !ctrl_q[vicr_pkg::VICR_B_NOREF];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_q <= 2'd0;
			tmo_q <= '0;
			refresh_q <= 1'b0;
		end else begin
			if (blank_mode && hblank_start) begin
				burst_q <= 2'(vicr_pkg::VICR_REFRESH_BURST);
				tmo_q <= '0; // defer timeout
			end else if (burst_q != 2'd0) begin
				burst_q <= burst_q - 2'd1;
				tmo_q <= '0;
			end else if (tmo_hit) begin
				tmo_q <= '0;
			end else begin
				tmo_q <= tmo_q + 1'b1;
			end
			refresh_q <= (burst_q != 2'd0) || (tmo_hit && !(blank_mode && hblank_start));
		end
	end
	assign refresh_req = refresh_q;
endmodule : vicr_regs

// ===== dv/vicr_regs_properties.sv
// concurrent checks for the display init register bank
`timescale 1ns/1ps
module vicr_regs_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire vicr_pkg::vicr_cfg_t cfg,
	input wire logic core_req,
	input wire logic core_grant,
	input wire logic scan_out_active,
	input wire logic scan_fetch_grant,
	input wire logic legacy_decode_ok,
	input wire logic [15:0] io_wr_port,
	input wire logic io_wr_req,
	input wire logic io_wr_ok,
	input wire logic [7:0] crtc_index,
	input wire logic crtc_wr,
	input wire logic [7:0] crtc_wr_mask,
	input wire logic misc_wr,
	input wire logic [7:0] misc_wr_mask,
	input wire logic clut_8bit,
	input wire logic sync_from_external
);
	// one clock domain for every check
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_r_waiting;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (s_r_waiting |=> s_axi_rvalid)
		else $error("read answer dropped");
	a_core_gate: assert property (core_grant == (core_req && !cfg.core_disable))
		else $error("core grant wrong");
	a_scan_block: assert property (cfg.no_scan_fetch && scan_out_active |-> !scan_fetch_grant)
		else $error("scan fetch granted");
	a_decode_off: assert property (cfg.legacy_decode_off |-> !legacy_decode_ok)
		else $error("legacy decode active");
	a_wake_block: assert property (cfg.legacy_decode_off && io_wr_req && io_wr_port == 16'h46E8 |-> !io_wr_ok)
		else $error("wake port write allowed");
	a_horiz_lock: assert property (cfg.locks[0] && crtc_wr && crtc_index == 8'h00 |-> crtc_wr_mask == 8'h00)
		else $error("horizontal timing writable");
	a_vsync_lock: assert property (cfg.locks[3] && misc_wr |-> !misc_wr_mask[7])
		else $error("vsync polarity writable");
	a_clut_width: assert property (clut_8bit == cfg.clut_8bit)
		else $error("palette width wrong");
	a_ext_sync: assert property (sync_from_external == cfg.ext_timing)
		else $error("sync source wrong");
endmodule : vicr_regs_checker
bind vicr_regs vicr_regs_checker u_chk (.*);

// ===== dv/tb_vicr_regs.sv
// self-checking bench for the display init register bank
`timescale 1ns/1ps
module tb_vicr_regs;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	vicr_pkg::vicr_cfg_t cfg;
	logic core_req = 1'b1, scan_out_active = 1'b1, scan_fetch_req = 1'b1, io_wr_req = 1'b1;
	logic legacy_mem_hit = 1'b1, legacy_io_hit = 1'b0, crtc_wr = 1'b1, misc_wr = 1'b1;
	logic seq_wr = 1'b1, window_write = 1'b1, hblank_start = 1'b0;
	logic [15:0] io_wr_port = 16'h46E8, io_base = 16'h0000, wake_port;
	logic [7:0] crtc_index = 8'h00, seq_index = 8'h01, crtc_wr_mask, misc_wr_mask, seq_wr_mask;
	logic [16:0] window_offset = 17'h00010;
	logic [11:0] refresh_period = 12'h008;
	logic core_grant, scan_fetch_grant, legacy_decode_ok, io_wr_ok, cfg_readback_en;
	logic sync_from_external, chain4_en, fast_blink, clut_8bit, refresh_req;
	logic [23:0] window_addr;
	int n_mismatch = 0, tests_run = 0, cnt;
	vicr_regs DUT (.*);
	always #2.5 aclk = ~aclk;
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	// bus write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (s_axi_awready !== 1'b1);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (s_axi_wready !== 1'b1);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		check(s_axi_bresp, 2'b00);
	endtask : wr
	// bus read, then compare data and response
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		check(s_axi_rdata, e);
		check(s_axi_rresp, r);
	endtask : rd_chk
	// count refresh requests over n edges
	task automatic count_ref(input int n);
		cnt = 0;
		repeat (n) begin
			@(posedge aclk);
			cnt += int'(refresh_req);
		end
	endtask : count_ref
	task automatic complete_run;
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	// watchdog
	initial begin
		#20000;
		n_mismatch++;
		complete_run();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(8'h28, 32'h00000038, 2'b00);
		rd_chk(8'h2C, 32'h00000000, 2'b00);
		rd_chk(8'h30, 32'h00000000, 2'b10);
		check(wake_port, 16'h46E8);
		check(cfg_readback_en, 1'b1);
		check(legacy_decode_ok, 1'b1);
		$display("test reset done");
		io_base <= 16'h0200;
		wr(8'h28, 32'h00001906);
		check({sync_from_external, clut_8bit, fast_blink}, 3'b111);
		check(wake_port, 16'h02C3);
		check({scan_fetch_grant, core_grant}, 2'b01);
		scan_out_active <= 1'b0;
		@(posedge aclk);
		check(scan_fetch_grant, 1'b1);
		wr(8'h28, 32'h00000200);
		check({legacy_decode_ok, io_wr_ok}, 2'b00);
		io_wr_port <= 16'h03C0;
		legacy_mem_hit <= 1'b0;
		legacy_io_hit <= 1'b1;
		@(posedge aclk);
		check({legacy_decode_ok, io_wr_ok}, 2'b01);
		wr(8'h28, 32'hFFFFDFFF); // decode test bit kept zero
		rd_chk(8'h28, 32'h007FDFFF, 2'b00);
		check({core_grant, cfg_readback_en}, 2'b00);
		$display("test control done");
		wr(8'h2C, 32'hFFFFFFFF);
		rd_chk(8'h2C, 32'h1FFFFFFF, 2'b00);
		check(crtc_wr_mask, 8'h00);
		check(misc_wr_mask, 8'h31);
		check(seq_wr_mask, 8'hFE);
		check(chain4_en, 1'b1);
		crtc_index <= 8'h06;
		@(posedge aclk);
		check(crtc_wr_mask, 8'h00);
		$display("test locks done");
		wr(8'h28, 32'h00008000);
		wr(8'h2C, 32'h00000C01);
		check(window_addr, 24'h028010);
		window_write <= 1'b0;
		@(posedge aclk);
		check(window_addr, 24'h038010);
		hblank_start <= 1'b1;
		@(posedge aclk);
		hblank_start <= 1'b0;
		count_ref(7);
		check(cnt, 3);
		wr(8'h28, 32'h00400000);
		count_ref(45);
		check(cnt, 5);
		$display("test window and refresh done");
		complete_run();
	end
endmodule : tb_vicr_regs
